// *** rtl/cmi_params.svh ***
// constants for the clock mode sequencer: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and the design files
`ifndef CMI_PARAMS_SVH
`define CMI_PARAMS_SVH

`define CMI_CLK_MHZ        125
`define CMI_AW             8

// register byte offsets
`define CMI_OFS_CTL1       8'h00
`define CMI_OFS_CTL2       8'h04
`define CMI_OFS_CTL3       8'h08
`define CMI_OFS_STAT       8'h0c
`define CMI_OFS_TRIM       8'h10

// clockgen_control_1 fields
`define CMI_C1_CLOCK_SOURCE_SELECT_HI     7
`define CMI_C1_CLOCK_SOURCE_SELECT_LO     6
`define CMI_C1_REFERENCE_DIVIDER_HI     5
`define CMI_C1_REFERENCE_DIVIDER_LO     3
`define CMI_C1_REFERENCE_SELECT       2
`define CMI_C1_INTERNAL_REF_CLOCK_ENABLE     1
// clockgen_control_2 fields
`define CMI_C2_BUS_FREQ_DIVIDER_HI     7
`define CMI_C2_BUS_FREQ_DIVIDER_LO     6
`define CMI_C2_LP          3
`define CMI_C2_OSCILLATOR_SELECT       2
`define CMI_C2_EXTERNAL_REF_CLOCK_ENABLE     1
// clockgen_control_3 fields
`define CMI_C3_LOOP_SELECT        6
`define CMI_C3_PLL_MULTIPLIER_HI     3
`define CMI_C3_PLL_MULTIPLIER_LO     0
// clockgen_status_control fields
`define CMI_ST_LOCK        6
`define CMI_ST_LOOP_STATUS       5
`define CMI_ST_IREFST      4
`define CMI_ST_CLOCK_SOURCE_STATUS_HI    3
`define CMI_ST_CLOCK_SOURCE_STATUS_LO    2
`define CMI_ST_OSCILLATOR_INITIALISED     1
`define CMI_ST_FINE_TRIM_BIT       0

// reset values
`define CMI_RST_CTL1       8'h04
`define CMI_RST_CTL2       8'h40
`define CMI_RST_CTL3       8'h00
`define CMI_RST_TRIM       8'h80
`define CMI_RST_FINE_TRIM_BIT      1'b0

// clock source select / status codes
`define CMI_SRC_LOOP       2'h0
`define CMI_SRC_INT        2'h1
`define CMI_SRC_EXT        2'h2
`define CMI_SRC_PLL        2'h3

`define CMI_FLL_MULT       11'h400
`define CMI_RESP_OKAY      2'h0
`define CMI_RESP_SLVERR    2'h2

// timing, in microseconds
`define CMI_T_IREFST_US    10
`define CMI_T_FLL_LOCK_US  1000
`define CMI_T_PLL_LOCK_US  1000
`define CMI_T_OSC_START_US 1000

`endif

// *** rtl/cmi_pkg.sv ***
// types of the clock mode sequencer: modes, bus carriers, state records
// assumes cmi_params.svh on the include path
`include "cmi_params.svh"

package cmi_pkg;

	typedef enum logic [7:0] {
		fll_engaged_internal      = 8'h01,
		fll_engaged_external      = 8'h02,
		fll_bypassed_external     = 8'h04,
		fll_bypassed_internal     = 8'h08,
		pll_engaged_external      = 8'h10,
		pll_bypassed_external     = 8'h20,
		low_power_internal_bypass = 8'h40,
		low_power_external_bypass = 8'h80
	} cmi_mode_e;

	typedef struct packed {
		logic                awvalid;
		logic [`CMI_AW-1:0]  awaddr;
		logic                wvalid;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bready;
		logic                arvalid;
		logic [`CMI_AW-1:0]  araddr;
		logic                rready;
	} cmi_axil_req_s;

	typedef struct packed {
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} cmi_axil_rsp_s;

	typedef struct packed {
		logic                wr_en;
		logic [`CMI_AW-1:0]  wr_addr;
		logic [31:0]         wr_data;
		logic [3:0]          wr_strb;
		logic [`CMI_AW-1:0]  rd_addr;
	} cmi_reg_req_s;

	typedef struct packed {
		logic [31:0]         rd_data;
		logic                rd_ok;
		logic                wr_ok;
	} cmi_reg_rsp_s;

	typedef struct packed {
		logic                int_ref_tick;
		logic                ext_ref_tick;
		logic                loop_tick;
		logic                ext_ref_present;
	} cmi_refs_s;

	typedef struct packed {
		cmi_mode_e           mode;
		logic [1:0]          out_src;
		logic [10:0]         loop_mult;
		logic [2:0]          ref_div;
		logic [1:0]          bus_div;
		logic                fll_en;
		logic                pll_en;
		logic                int_ref_run;
		logic                ext_ref_run;
		logic [7:0]          trim;
		logic                fine_trim_bit;
		logic                bus_tick;
	} cmi_gen_s;

	typedef struct packed {
		logic                aw_got;
		logic                w_got;
		logic [`CMI_AW-1:0]  addr;
		logic [31:0]         data;
		logic [3:0]          strb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} cmi_axil_state_s;

	typedef struct packed {
		logic [7:0]          cnt;
		logic                tick;
	} cmi_div_state_s;

	typedef struct packed {
		logic [7:0]          ctl1;
		logic [7:0]          ctl2;
		logic [7:0]          ctl3;
		logic [7:0]          trim;
		logic                fine_trim_bit;
		cmi_mode_e           mode;
		logic                iref_ok;
		logic [23:0]         iref_cnt;
		logic                osc_init;
		logic [23:0]         osc_cnt;
		logic                lock;
		logic [23:0]         lock_cnt;
		logic                irefst;
		logic                loop_status;
		logic [1:0]          clock_source_status;
	} cmi_state_s;

endpackage

// *** rtl/cmi_axil_slave.sv ***
// axi4-lite slave front end for the clock mode sequencer registers
// assumes one write and one read outstanding; register side answers combinationally
`timescale 1ns/1ps
`include "cmi_params.svh"

module cmi_axil_slave (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst,
	// bus
	input  wire cmi_pkg::cmi_axil_req_s axi_req,
	output      cmi_pkg::cmi_axil_rsp_s axi_rsp,
	// register side
	output      cmi_pkg::cmi_reg_req_s  reg_req,
	input  wire cmi_pkg::cmi_reg_rsp_s  reg_rsp
);

	cmi_pkg::cmi_axil_state_s q;
	cmi_pkg::cmi_axil_state_s d;
	logic                      aw_rdy;
	logic                      w_rdy;
	logic                      wr_fire;

	assign aw_rdy  = !q.aw_got && !q.bvalid;
	assign w_rdy   = !q.w_got && !q.bvalid;
	assign wr_fire = q.aw_got && q.w_got && !q.bvalid;

	always_comb begin
		d = q;
		if (axi_req.awvalid && aw_rdy) begin
			d.aw_got = 1'b1;
			d.addr   = axi_req.awaddr;
		end
		if (axi_req.wvalid && w_rdy) begin
			d.w_got = 1'b1;
			d.data  = axi_req.wdata;
			d.strb  = axi_req.wstrb;
		end
		// address and data both held: commit and answer
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = reg_rsp.wr_ok ? `CMI_RESP_OKAY : `CMI_RESP_SLVERR;
		end else if (q.bvalid && axi_req.bready) begin
			d.bvalid = 1'b0;
		end
		if (axi_req.arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rdata  = reg_rsp.rd_data;
			d.rresp  = reg_rsp.rd_ok ? `CMI_RESP_OKAY : `CMI_RESP_SLVERR;
		end else if (q.rvalid && axi_req.rready) begin
			d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp.awready = aw_rdy;
	assign axi_rsp.wready  = w_rdy;
	assign axi_rsp.bvalid  = q.bvalid;
	assign axi_rsp.bresp   = q.bresp;
	assign axi_rsp.arready = !q.rvalid;
	assign axi_rsp.rvalid  = q.rvalid;
	assign axi_rsp.rdata   = q.rdata;
	assign axi_rsp.rresp   = q.rresp;

	assign reg_req.wr_en   = wr_fire;
	assign reg_req.wr_addr = q.addr;
	assign reg_req.wr_data = q.data;
	assign reg_req.wr_strb = q.strb;
	assign reg_req.rd_addr = axi_req.araddr;

endmodule

// *** rtl/cmi_bus_div.sv ***
// bus clock divider: counts generator source ticks by twice the bus divider
// assumes src_tick is a one-cycle pulse per source clock edge
`timescale 1ns/1ps

module cmi_bus_div (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// source and setting
	input  wire logic       src_tick,
	input  wire logic [1:0] div_code,
	// result
	output      logic       bus_tick
);

	cmi_pkg::cmi_div_state_s q;
	cmi_pkg::cmi_div_state_s d;
	logic [7:0]              last;

	// generator output is source / 2^code; bus is that / 2
	assign last = (8'h02 << div_code) - 8'h01;

	always_comb begin
		d      = q;
		d.tick = 1'b0;
		if (src_tick) begin
			// compare with >= so a smaller divider applies at once
			if (q.cnt >= last) begin
				d.cnt  = 8'h00;
				d.tick = 1'b1;
			end else begin
				d.cnt = q.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus_tick = q.tick;

endmodule

// *** rtl/cmi_sequencer.sv ***
// clock mode sequencer: control registers, mode tracking, status handshakes
// assumes inputs synchronous to mclk; reference edges arrive as one-cycle ticks
// Summary of operation
// - reset into fll_engaged_internal, bus divide-by-two
// - internal reference settles before fll lock count
// - from reset only three modes reachable directly
// - internal reference runs when enable bit set
// - oscillator_initialised set after oscillator start-up
// - fll bypassed external: fll locks, status reads %10
// - select %01 reported as %01 in status
// - select change mirrored in status field only once the mode moves
// - bus clock is generator output over two
// - fll engaged output is reference times 1024
// - pll engaged output is divided reference times four times the multiplier field
// - bypass modes pass selected reference, no multiply
// - reference divider code %000 after reset
// - unavailable source keeps previous clock selected
// - select %10 external, %01 internal, %00 loop
// - bus divider write takes effect immediately
`timescale 1ns/1ps
`include "cmi_params.svh"

module cmi_sequencer #(
	parameter int unsigned FLL_LOCK_CYC  = `CMI_T_FLL_LOCK_US * `CMI_CLK_MHZ,
	parameter int unsigned PLL_LOCK_CYC  = `CMI_T_PLL_LOCK_US * `CMI_CLK_MHZ,
	parameter int unsigned OSC_START_CYC = `CMI_T_OSC_START_US * `CMI_CLK_MHZ
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// register bus
	input  wire cmi_pkg::cmi_axil_req_s axi_req,
	output      cmi_pkg::cmi_axil_rsp_s axi_rsp,
	// reference and loop clock ticks
	input  wire cmi_pkg::cmi_refs_s     refs,
	// generator controls and bus clock
	output      cmi_pkg::cmi_gen_s      gen
);

	localparam logic [23:0] IREFST_CYC = 24'(`CMI_T_IREFST_US * `CMI_CLK_MHZ);
	localparam logic [23:0] FLL_LAST   = 24'(FLL_LOCK_CYC - 1);
	localparam logic [23:0] PLL_LAST   = 24'(PLL_LOCK_CYC - 1);
	localparam logic [23:0] OSC_LAST   = 24'(OSC_START_CYC - 1);
	localparam logic [23:0] IREF_LAST  = IREFST_CYC - 24'h000001;

	cmi_pkg::cmi_reg_req_s  reg_req;
	cmi_pkg::cmi_reg_rsp_s  reg_rsp;
	cmi_pkg::cmi_state_s    q;
	cmi_pkg::cmi_state_s    d;
	cmi_pkg::cmi_mode_e     req_mode;
	logic                   req_valid;
	logic                   ext_ok;
	logic                   legal;
	logic                   avail;
	logic                   int_run;
	logic                   osc_need;
	logic                   loop_on;
	logic                   loop_ref_ok;
	logic                   src_tick;
	logic                   bus_tick;
	logic [7:0]             stat_byte;

	function automatic logic is_internal(input cmi_pkg::cmi_mode_e m);
		is_internal = (m == cmi_pkg::fll_engaged_internal) ||
			(m == cmi_pkg::fll_bypassed_internal) ||
			(m == cmi_pkg::low_power_internal_bypass);
	endfunction

	function automatic logic is_low_power(input cmi_pkg::cmi_mode_e m);
		is_low_power = (m == cmi_pkg::low_power_internal_bypass) ||
			(m == cmi_pkg::low_power_external_bypass);
	endfunction

	function automatic logic is_engaged(input cmi_pkg::cmi_mode_e m);
		is_engaged = (m == cmi_pkg::fll_engaged_internal) ||
			(m == cmi_pkg::fll_engaged_external) ||
			(m == cmi_pkg::pll_engaged_external);
	endfunction

	function automatic logic is_pll(input cmi_pkg::cmi_mode_e m);
		is_pll = (m == cmi_pkg::pll_engaged_external) ||
			(m == cmi_pkg::pll_bypassed_external);
	endfunction

	// clock status reported for a mode actually in use
	function automatic logic [1:0] status_of(input cmi_pkg::cmi_mode_e m);
		unique case (m)
			cmi_pkg::fll_engaged_internal,
			cmi_pkg::fll_engaged_external:      status_of = `CMI_SRC_LOOP;
			cmi_pkg::pll_engaged_external:      status_of = `CMI_SRC_PLL;
			cmi_pkg::fll_bypassed_internal,
			cmi_pkg::low_power_internal_bypass: status_of = `CMI_SRC_INT;
			default:                            status_of = `CMI_SRC_EXT;
		endcase
	endfunction

	// mode asked for by the control bits
	always_comb begin
		req_valid = 1'b1;
		req_mode  = q.mode;
		unique case (q.ctl1[`CMI_C1_CLOCK_SOURCE_SELECT_HI:`CMI_C1_CLOCK_SOURCE_SELECT_LO])
			`CMI_SRC_LOOP: begin
				if (q.ctl1[`CMI_C1_REFERENCE_SELECT]) begin
					req_mode  = cmi_pkg::fll_engaged_internal;
					req_valid = !q.ctl3[`CMI_C3_LOOP_SELECT];
				end else if (q.ctl3[`CMI_C3_LOOP_SELECT]) begin
					req_mode = cmi_pkg::pll_engaged_external;
				end else begin
					req_mode = cmi_pkg::fll_engaged_external;
				end
			end
			`CMI_SRC_INT: begin
				req_mode = q.ctl2[`CMI_C2_LP] ? cmi_pkg::low_power_internal_bypass :
					cmi_pkg::fll_bypassed_internal;
			end
			`CMI_SRC_EXT: begin
				if (q.ctl2[`CMI_C2_LP]) begin
					req_mode = cmi_pkg::low_power_external_bypass;
				end else if (q.ctl3[`CMI_C3_LOOP_SELECT]) begin
					req_mode = cmi_pkg::pll_bypassed_external;
				end else begin
					req_mode = cmi_pkg::fll_bypassed_external;
				end
			end
			default: begin
				req_valid = 1'b0;
			end
		endcase
	end

	// external source usable: present, and started if it is an oscillator
	assign ext_ok = refs.ext_ref_present && (!q.ctl2[`CMI_C2_OSCILLATOR_SELECT] || q.osc_init);

	assign legal = (q.mode != cmi_pkg::fll_engaged_internal) ||
		(req_mode == cmi_pkg::fll_engaged_internal) ||
		(req_mode == cmi_pkg::fll_engaged_external) ||
		(req_mode == cmi_pkg::fll_bypassed_external) ||
		(req_mode == cmi_pkg::fll_bypassed_internal);

	assign avail = is_internal(req_mode) || ext_ok;

	assign int_run = q.ctl1[`CMI_C1_INTERNAL_REF_CLOCK_ENABLE] || is_internal(q.mode);

	assign osc_need = q.ctl2[`CMI_C2_OSCILLATOR_SELECT] && refs.ext_ref_present &&
		(q.ctl2[`CMI_C2_EXTERNAL_REF_CLOCK_ENABLE] || !is_internal(q.mode) || !is_internal(req_mode));

	assign loop_on     = !is_low_power(q.mode);
	assign loop_ref_ok = is_internal(q.mode) ? q.iref_ok : ext_ok;

	always_comb begin
		d = q;
		// register writes, low byte lane only
		if (reg_req.wr_en && reg_req.wr_strb[0]) begin
			unique case (reg_req.wr_addr)
				`CMI_OFS_CTL1: d.ctl1  = reg_req.wr_data[7:0];
				`CMI_OFS_CTL2: d.ctl2  = reg_req.wr_data[7:0];
				`CMI_OFS_CTL3: d.ctl3  = reg_req.wr_data[7:0];
				`CMI_OFS_STAT: d.fine_trim_bit = reg_req.wr_data[`CMI_ST_FINE_TRIM_BIT];
				`CMI_OFS_TRIM: d.trim  = reg_req.wr_data[7:0];
				default:       d.ctl1  = q.ctl1;
			endcase
		end
		// mode moves only to a legal, available request
		if (req_valid && legal && avail) begin
			d.mode = req_mode;
		end
		d.clock_source_status  = status_of(d.mode);
		d.irefst = is_internal(d.mode);
		d.loop_status  = is_pll(d.mode) ||
			((d.mode == cmi_pkg::low_power_external_bypass) && q.ctl3[`CMI_C3_LOOP_SELECT]);
		// internal reference settling
		if (!int_run) begin
			d.iref_cnt = '0;
			d.iref_ok  = 1'b0;
		end else if (!q.iref_ok) begin
			if (q.iref_cnt == IREF_LAST) begin
				d.iref_ok = 1'b1;
			end else begin
				d.iref_cnt = q.iref_cnt + 24'h000001;
			end
		end
		// oscillator start-up
		if (!osc_need) begin
			d.osc_cnt  = '0;
			d.osc_init = 1'b0;
		end else if (!q.osc_init) begin
			if (q.osc_cnt == OSC_LAST) begin
				d.osc_init = 1'b1;
			end else begin
				d.osc_cnt = q.osc_cnt + 24'h000001;
			end
		end
		// lock restarts whenever the loop's reference or selection changes
		if (!loop_on || !loop_ref_ok || (d.irefst != q.irefst) || (d.loop_status != q.loop_status)) begin
			d.lock_cnt = '0;
			d.lock     = 1'b0;
		end else if (!q.lock) begin
			if (q.lock_cnt == (q.loop_status ? PLL_LAST : FLL_LAST)) begin
				d.lock = 1'b1;
			end else begin
				d.lock_cnt = q.lock_cnt + 24'h000001;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			q        <= '0;
			q.ctl1   <= `CMI_RST_CTL1;
			q.ctl2   <= `CMI_RST_CTL2;
			q.ctl3   <= `CMI_RST_CTL3;
			q.trim   <= `CMI_RST_TRIM;
			q.fine_trim_bit  <= `CMI_RST_FINE_TRIM_BIT;
			q.mode   <= cmi_pkg::fll_engaged_internal;
			q.irefst <= 1'b1;
			q.clock_source_status  <= `CMI_SRC_LOOP;
		end else begin
			q <= d;
		end
	end

	// register reads
	always_comb begin
		stat_byte                                  = 8'h00;
		stat_byte[`CMI_ST_LOCK]                    = q.lock;
		stat_byte[`CMI_ST_LOOP_STATUS]                   = q.loop_status;
		stat_byte[`CMI_ST_IREFST]                  = q.irefst;
		stat_byte[`CMI_ST_CLOCK_SOURCE_STATUS_HI:`CMI_ST_CLOCK_SOURCE_STATUS_LO] = q.clock_source_status;
		stat_byte[`CMI_ST_OSCILLATOR_INITIALISED]                 = q.osc_init;
		stat_byte[`CMI_ST_FINE_TRIM_BIT]                   = q.fine_trim_bit;
		reg_rsp.rd_ok   = 1'b1;
		reg_rsp.rd_data = 32'h00000000;
		unique case (reg_req.rd_addr)
			`CMI_OFS_CTL1: reg_rsp.rd_data[7:0] = q.ctl1;
			`CMI_OFS_CTL2: reg_rsp.rd_data[7:0] = q.ctl2;
			`CMI_OFS_CTL3: reg_rsp.rd_data[7:0] = q.ctl3;
			`CMI_OFS_STAT: reg_rsp.rd_data[7:0] = stat_byte;
			`CMI_OFS_TRIM: reg_rsp.rd_data[7:0] = q.trim;
			default:       reg_rsp.rd_ok        = 1'b0;
		endcase
		unique case (reg_req.wr_addr)
			`CMI_OFS_CTL1,
			`CMI_OFS_CTL2,
			`CMI_OFS_CTL3,
			`CMI_OFS_STAT,
			`CMI_OFS_TRIM: reg_rsp.wr_ok = 1'b1;
			default:       reg_rsp.wr_ok = 1'b0;
		endcase
	end

	cmi_axil_slave u_bus (
		.mclk    (mclk),
		.rst     (rst),
		.axi_req (axi_req),
		.axi_rsp (axi_rsp),
		.reg_req (reg_req),
		.reg_rsp (reg_rsp)
	);

	// engaged modes take the loop; bypass modes pass the reference
	always_comb begin
		if (is_engaged(q.mode)) begin
			src_tick = refs.loop_tick;
		end else if (is_internal(q.mode)) begin
			src_tick = refs.int_ref_tick;
		end else begin
			src_tick = refs.ext_ref_tick;
		end
	end

	cmi_bus_div u_div (
		.mclk     (mclk),
		.rst      (rst),
		.src_tick (src_tick),
		.div_code (q.ctl2[`CMI_C2_BUS_FREQ_DIVIDER_HI:`CMI_C2_BUS_FREQ_DIVIDER_LO]),
		.bus_tick (bus_tick)
	);

	assign gen.mode        = q.mode;
	assign gen.out_src     = q.clock_source_status;
	assign gen.loop_mult   = q.loop_status ? {5'h00, q.ctl3[`CMI_C3_PLL_MULTIPLIER_HI:`CMI_C3_PLL_MULTIPLIER_LO], 2'h0} :
		`CMI_FLL_MULT;
	assign gen.ref_div     = q.ctl1[`CMI_C1_REFERENCE_DIVIDER_HI:`CMI_C1_REFERENCE_DIVIDER_LO];
	assign gen.bus_div     = q.ctl2[`CMI_C2_BUS_FREQ_DIVIDER_HI:`CMI_C2_BUS_FREQ_DIVIDER_LO];
	assign gen.fll_en      = loop_on && !q.loop_status;
	assign gen.pll_en      = loop_on && q.loop_status;
	assign gen.int_ref_run = int_run;
	assign gen.ext_ref_run = q.ctl2[`CMI_C2_EXTERNAL_REF_CLOCK_ENABLE] || !is_internal(q.mode);
	assign gen.trim        = q.trim;
	assign gen.fine_trim_bit       = q.fine_trim_bit;
	assign gen.bus_tick    = bus_tick;

endmodule

// *** test/cmi_sequencer_props.sv ***
// concurrent checks on the clock mode sequencer ports
// assumes bind onto cmi_sequencer, single clock mclk, sync reset rst
`timescale 1ns/1ps
`include "cmi_params.svh"

module cmi_sequencer_props (
	// clock and reset
	input wire logic                   mclk,
	input wire logic                   rst,
	// watched ports
	input wire cmi_pkg::cmi_axil_req_s axi_req,
	input wire cmi_pkg::cmi_axil_rsp_s axi_rsp,
	input wire cmi_pkg::cmi_refs_s     refs,
	input wire cmi_pkg::cmi_gen_s      gen
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	logic ctl2_take;
	assign ctl2_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
		&& axi_req.awaddr == `CMI_OFS_CTL2 && axi_req.wstrb[0];

	reset_state_a: assert property (
		$fell(rst) |-> gen.mode == cmi_pkg::fll_engaged_internal && gen.bus_div == 2'h1
		&& gen.ref_div == 3'h0) else $error("wrong state after reset");
	bus_half_a: assert property (gen.bus_tick |=> !gen.bus_tick)
		else $error("bus tick faster than half rate");
	div_now_a: assert property (
		ctl2_take |-> ##2 gen.bus_div == $past(axi_req.wdata[7:6], 2))
		else $error("bus divider write not applied");
	reset_exit_a: assert property (gen.mode == cmi_pkg::fll_engaged_internal |=>
		gen.mode inside {cmi_pkg::fll_engaged_internal, cmi_pkg::fll_engaged_external,
		cmi_pkg::fll_bypassed_external, cmi_pkg::fll_bypassed_internal})
		else $error("illegal mode left from reset mode");
	keep_source_a: assert property (
		gen.mode == cmi_pkg::fll_engaged_internal && !refs.ext_ref_present |=>
		gen.mode inside {cmi_pkg::fll_engaged_internal, cmi_pkg::fll_bypassed_internal})
		else $error("external mode taken without source");
	int_src_a: assert property (
		gen.mode inside {cmi_pkg::fll_bypassed_internal, cmi_pkg::low_power_internal_bypass}
		|-> gen.out_src == `CMI_SRC_INT) else $error("internal bypass source wrong");
	ext_src_a: assert property (gen.mode inside {cmi_pkg::fll_bypassed_external,
		cmi_pkg::pll_bypassed_external, cmi_pkg::low_power_external_bypass}
		|-> gen.out_src == `CMI_SRC_EXT) else $error("external bypass source wrong");
	fll_out_a: assert property (
		gen.mode inside {cmi_pkg::fll_engaged_internal, cmi_pkg::fll_engaged_external} |->
		gen.out_src == `CMI_SRC_LOOP && gen.loop_mult == `CMI_FLL_MULT && gen.fll_en)
		else $error("fll engaged output wrong");
	int_run_a: assert property (gen.mode == cmi_pkg::fll_engaged_internal |-> gen.int_ref_run)
		else $error("internal reference stopped");
	pll_out_a: assert property (
		gen.mode == cmi_pkg::pll_engaged_external |->
		gen.out_src == `CMI_SRC_PLL && gen.pll_en && !gen.fll_en)
		else $error("pll engaged output wrong");

	cover property (gen.mode == cmi_pkg::fll_bypassed_internal);
	cover property (gen.mode == cmi_pkg::fll_bypassed_external);
	cover property (gen.mode == cmi_pkg::fll_engaged_external);
	cover property (gen.mode == cmi_pkg::pll_engaged_external);
endmodule

bind cmi_sequencer cmi_sequencer_props props_u (
	.mclk(mclk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp), .refs(refs), .gen(gen));

// *** test/cmi_sequencer_bench.sv ***
// self-checking bench for the clock mode sequencer
// assumes design files and checker compiled first
`timescale 1ns/1ps
`include "cmi_params.svh"

module cmi_sequencer_bench;
	logic                   mclk;
	logic                   rst;
	logic                   ext_present;
	logic [15:0]            cyc;
	logic [31:0]            rd;
	logic [1:0]             resp;
	int                     fails;
	int                     samples_checked;
	int                     nticks;
	cmi_pkg::cmi_axil_req_s req;
	cmi_pkg::cmi_axil_rsp_s rsp;
	cmi_pkg::cmi_refs_s     refs;
	cmi_pkg::cmi_gen_s      gen;

	cmi_sequencer #(.FLL_LOCK_CYC(20), .PLL_LOCK_CYC(20), .OSC_START_CYC(20)) dut_u (
		.mclk   (mclk),
		.rst    (rst),
		.axi_req(req),
		.axi_rsp(rsp),
		.refs   (refs),
		.gen    (gen)
	);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// loop tick every 2nd cycle, internal every 4th, external every 3rd
	always @(posedge mclk) begin
		cyc <= cyc + 16'h1;
		refs.loop_tick <= cyc[0];
		refs.int_ref_tick <= cyc[1:0] == 2'h0;
		refs.ext_ref_tick <= ext_present && (cyc % 3 == 0);
		refs.ext_ref_present <= ext_present;
		if (gen.bus_tick === 1'b1) nticks++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h0, d};
		req.bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			n++;
		end while (!rsp.bvalid && n < 50);
		resp = rsp.bresp;
		req.bready <= 1'b0;
		if (n >= 50) fails++;
	endtask

	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge mclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (rsp.arready) req.arvalid <= 1'b0;
			n++;
		end while (!rsp.rvalid && n < 50);
		rd = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
		if (n >= 50) fails++;
	endtask

	// reread status until masked field matches
	task automatic poll(input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		do begin
			rdr(`CMI_OFS_STAT);
			n++;
		end while ((rd[7:0] & m) !== v && n < 1000);
		chk(rd[7:0] & m, v);
	endtask

	task automatic t_reset;
		logic [7:0] ad [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h0c, 8'h14};
		logic [7:0] ex [6] = '{8'h04, 8'h40, 8'h00, 8'h80, 8'h10, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rdr(ad[i]);
			chk(rd, {24'h0, ex[i]});
			chk(resp, (i == 5) ? `CMI_RESP_SLVERR : `CMI_RESP_OKAY);
		end
		$display("test reset done");
	endtask

	task automatic t_trim;
		wr(`CMI_OFS_TRIM, 8'h5a);
		chk(resp, `CMI_RESP_OKAY);
		wr(`CMI_OFS_STAT, 8'hff);
		rdr(`CMI_OFS_TRIM);
		chk(rd, 32'h5a);
		rdr(`CMI_OFS_STAT);
		chk(rd & 32'hffffff03, 32'h1);
		chk(gen.trim, 8'h5a);
		chk(gen.fine_trim_bit, 1'b1);
		poll(8'h50, 8'h50);
		$display("test trim and lock done");
	endtask

	task automatic t_busdiv(input logic [1:0] d, input int exp);
		wr(`CMI_OFS_CTL2, {d, 6'h0});
		repeat (16) @(posedge mclk);
		nticks = 0;
		repeat (400) @(posedge mclk);
		chk(nticks >= exp - 1 && nticks <= exp + 1, 1'b1);
		$display("test bus divider %0d done", d);
	endtask

	task automatic t_modes;
		wr(`CMI_OFS_CTL2, 8'h48);
		wr(`CMI_OFS_CTL1, 8'h44);
		repeat (4) @(posedge mclk);
		chk(gen.mode, cmi_pkg::fll_engaged_internal);
		wr(`CMI_OFS_CTL2, 8'h40);
		poll(8'h0c, 8'h04);
		chk(gen.mode, cmi_pkg::fll_bypassed_internal);
		wr(`CMI_OFS_CTL1, 8'h04);
		poll(8'h0c, 8'h00);
		wr(`CMI_OFS_CTL1, 8'h80);
		repeat (4) @(posedge mclk);
		chk(gen.mode, cmi_pkg::fll_engaged_internal);
		poll(8'h1c, 8'h10);
		wr(`CMI_OFS_CTL1, 8'h04);
		$display("test internal modes done");
	endtask

	task automatic t_ext;
		ext_present <= 1'b1;
		wr(`CMI_OFS_CTL2, 8'h46);
		poll(8'h02, 8'h02);
		wr(`CMI_OFS_CTL1, 8'hba);
		poll(8'h1c, 8'h08);
		poll(8'h40, 8'h40);
		chk(gen.mode, cmi_pkg::fll_bypassed_external);
		chk(gen.int_ref_run, 1'b1);
		wr(`CMI_OFS_CTL1, 8'h3a);
		poll(8'h5c, 8'h40);
		chk(gen.mode, cmi_pkg::fll_engaged_external);
		chk(gen.loop_mult, `CMI_FLL_MULT);
		wr(`CMI_OFS_CTL1, 8'h92);
		wr(`CMI_OFS_CTL3, 8'h44);
		poll(8'h6c, 8'h68);
		wr(`CMI_OFS_CTL1, 8'h12);
		poll(8'h6c, 8'h6c);
		chk(gen.mode, cmi_pkg::pll_engaged_external);
		chk(gen.loop_mult, 11'h010);
		$display("test external modes done");
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		req = '0;
		req.wstrb = 4'h1;
		refs = '0;
		ext_present = 1'b0;
		cyc = '0;
		fails = 0;
		samples_checked = 0;
		nticks = 0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_trim();
		t_busdiv(2'h1, 50);
		t_busdiv(2'h0, 100);
		t_busdiv(2'h1, 50);
		t_modes();
		t_ext();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		end_of_test();
	end
endmodule
